// >>> bench/sacir_top_tb.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Self-checking bench: register map, pulse shaper, break, bit error
// ----------------------------------------------------------------
module sacir_top_tb;
    logic        MCLK = 1'b0;           // 20 MHz clock
    logic        NRST = 1'b0;           // Synchronous reset, low
    logic        HSEL = 1'b0;           // Bus select
    logic        HWRITE = 1'b0;         // Write transfer
    logic [1:0]  HTRANS = 2'h0;         // Transfer type
    logic [2:0]  HSIZE = 3'h2;          // Word transfers only
    logic [31:0] HADDR = 32'h0;         // Byte address
    logic [31:0] HWDATA = 32'h0;        // Write data
    logic        BIT_START = 1'b0;      // Bit boundary pulse
    logic        BIT_TICK = 1'b0;       // Phase tick
    logic        TX_BIT = 1'b1;         // Transmitter bit
    logic        TX_ACTIVE = 1'b0;      // Transmitter busy
    logic        RXD_PIN = 1'b1;        // Receive pin
    logic        rd_on = 1'b0;          // Read data phase in progress
    wire  logic [31:0] HRDATA;          // Read data
    wire  logic  HREADYOUT;             // Slave ready, fed back as bus ready
    wire  logic  HRESP;                 // Response
    wire  logic  TXD_PIN;               // Transmit pin
    wire  logic  RX_DATA;               // Demodulated data
    wire  logic  IRQ;                   // Interrupt request
    logic [31:0] exp_q[$];              // Expected read data, oldest first
    logic [31:0] seed = 32'h0001082e;   // Random state
    int          err_total = 0;         // Mismatches
    int          check_count = 0;       // Comparisons
    int          hi = 0;                // Transmit pin high samples
    int          w_tab[4] = '{6, 2, 1, 8};  // Pulse width in ticks per code

    always #25 MCLK = ~MCLK;

    // Short break so the run stays brief
    sacir_top #(.BREAK_BITS(4'h3)) dut_u (.MCLK(MCLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BIT_START(BIT_START),
        .BIT_TICK(BIT_TICK), .TX_BIT(TX_BIT), .TX_ACTIVE(TX_ACTIVE), .RXD_PIN(RXD_PIN),
        .TXD_PIN(TXD_PIN), .RX_DATA(RX_DATA), .IRQ(IRQ));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    // One single transfer; a read notes its expected data for the monitor
    task automatic bus(input logic w, input logic [2:0] idx, input logic [31:0] d);
        @(posedge MCLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {27'h0, idx, 2'h0};
        @(posedge MCLK);
        while (HREADYOUT !== 1'b1) @(posedge MCLK);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= w ? d : 32'h0;
        if (!w) exp_q.push_back(d);
        rd_on <= !w;
        @(posedge MCLK);
        while (HREADYOUT !== 1'b1) @(posedge MCLK);
        rd_on <= 1'b0;
    endtask

    // Read data is taken at the rising edge that ends the data phase
    always @(posedge MCLK)
        if (rd_on && HREADYOUT === 1'b1 && exp_q.size() > 0)
        begin
            chk("HRDATA", exp_q.pop_front(), HRDATA);
            chk("HRESP", 32'h0, {31'h0, HRESP});
        end

    // Bits of 32 ticks, one tick per clock, counting high transmit samples
    task automatic bits(input int n, input logic tx, input logic rx);
        for (int b = 0; b < n * 32; b++)
        begin
            @(posedge MCLK);
            BIT_START <= (b % 32 == 0);
            BIT_TICK <= 1'b1;
            TX_BIT <= tx;
            RXD_PIN <= rx;
            @(negedge MCLK);
            hi += (TXD_PIN === 1'b1);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #2000000;
        err_total++;
        final_report();
    end

    initial
    begin
        repeat (8) @(posedge MCLK);
        NRST <= 1'b1;
        bus(1'b1, sacir_pkg::IDX_ACR2, 32'hff);
        bus(1'b0, sacir_pkg::IDX_ACR2, 32'h0);
        bus(1'b1, sacir_pkg::IDX_MAP, 32'h1);
        bus(1'b0, sacir_pkg::IDX_ACR2, 32'h0);
        seed = xs(seed);
        bus(1'b1, sacir_pkg::IDX_ACR2, {24'h0, seed[7:0]});
        bus(1'b0, sacir_pkg::IDX_ACR2, {24'h0, seed[7:0] & 8'he7});
        bus(1'b1, 3'h6, 32'hff);
        bus(1'b0, 3'h6, 32'h0);
        bus(1'b1, sacir_pkg::IDX_ACR2, 32'h0);
        hi = 0;
        bits(1, 1'b0, 1'b1);
        chk("plain", 32'h1, 32'(hi));
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b1, sacir_pkg::IDX_ACR2, {24'h0, 1'b1, 2'(c), 5'h0});
            // A silent bit first aligns the phase so no stray pulse is counted
            bits(1, 1'b1, 1'b0);
            hi = 0;
            bits(2, 1'b0, 1'b0);
            bits(1, 1'b1, 1'b0);
            chk("pulse", 32'(2 * w_tab[c]), 32'(hi));
            chk("RX_DATA", 32'h1, {31'h0, RX_DATA});
        end
        bus(1'b1, sacir_pkg::IDX_ACR2, 32'h1);
        bus(1'b1, sacir_pkg::IDX_ACR1, 32'h1);
        bus(1'b1, sacir_pkg::IDX_MASK, 32'h1);
        bits(4, 1'b1, 1'b0);
        chk("IRQ", 32'h1, {31'h0, IRQ});
        bus(1'b0, sacir_pkg::IDX_STAT, 32'h1);
        repeat (2) @(negedge MCLK);
        chk("IRQ", 32'h0, {31'h0, IRQ});
        bus(1'b1, sacir_pkg::IDX_ACR2, 32'h0);
        bits(4, 1'b1, 1'b0);
        bus(1'b0, sacir_pkg::IDX_STAT, 32'h0);
        bus(1'b1, sacir_pkg::IDX_ACR1, 32'h2);
        bus(1'b1, sacir_pkg::IDX_MASK, 32'h2);
        // Every detecting mode must flag a returned zero against a sent one
        for (int m = 1; m < 4; m++)
        begin
            bus(1'b1, sacir_pkg::IDX_ACR2, {29'h0, 2'(m), 1'b0});
            TX_ACTIVE <= 1'b1;
            bits(2, 1'b1, 1'b0);
            chk("IRQ", 32'h1, {31'h0, IRQ});
            TX_ACTIVE <= 1'b0;
            if (m < 3)
                bus(1'b0, sacir_pkg::IDX_STAT, 32'h2);
        end
        bus(1'b1, sacir_pkg::IDX_ACR1, 32'h0);
        repeat (2) @(negedge MCLK);
        chk("IRQ", 32'h0, {31'h0, IRQ});
        bus(1'b0, sacir_pkg::IDX_STAT, 32'h2);
        final_report();
    end
endmodule

// >>> design/sacir_irphy.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bit phase, infrared narrow pulse shaper and demodulator
// ----------------------------------------------------------------
module sacir_irphy (
    input  wire logic       clk,        // Module clock
    input  wire logic       rst_n,      // Synchronous reset, low
    input  wire logic       ir_en,      // Infrared path on
    input  wire logic [1:0] pulse_sel,  // Narrow pulse code
    input  wire logic       bit_start,  // First tick of a bit
    input  wire logic       bit_tick,   // 32 ticks per bit
    input  wire logic       tx_bit,     // Bit from transmitter
    input  wire logic       rxd_in,     // Receive pin
    output logic      [4:0] phase,      // Tick within the bit
    output logic            txd_out,    // Transmit pin
    output logic            rx_data     // Bit to receiver
);

    logic [4:0] phase_q, phase_d;       // Bit phase counter
    logic       txd_q, txd_d;           // Pin driver
    logic       rxl_q, rxl_d;           // Pulse seen in this bit
    logic       rxd_q, rxd_d;           // Receive output
    logic [4:0] width;                  // Pulse width in ticks

    // ------------------------------------------------------------
    // Pulse width decode
    // ------------------------------------------------------------
    always_comb
    begin
        case (pulse_sel)
            sacir_pkg::NP_1_4:  width = sacir_pkg::W_1_4;
            sacir_pkg::NP_1_32: width = sacir_pkg::W_1_32;
            sacir_pkg::NP_1_16: width = sacir_pkg::W_1_16;
            sacir_pkg::NP_3_16: width = sacir_pkg::W_3_16;
            default:            width = sacir_pkg::W_3_16;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        phase_d = phase_q;
        if (bit_start)
            phase_d = 5'h00;
        else if (bit_tick)
            phase_d = phase_q + 5'h01;
        // A zero goes out as a short high pulse, a one as silence
        if (ir_en)
            txd_d = !tx_bit && (phase_q < width);
        else
            txd_d = tx_bit;
        // A pulse anywhere in the bit marks a received zero
        if (!ir_en)
            rxl_d = 1'b0;
        else if (bit_start)
            rxl_d = rxd_in;
        else
            rxl_d = rxl_q | rxd_in;
        // A new bit forgets the pulse seen in the bit before it
        rxd_d = ir_en ? !((rxl_q && !bit_start) | rxd_in) : rxd_in;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            phase_q <= 5'h00;
            txd_q   <= 1'b1;
            rxl_q   <= 1'b0;
            rxd_q   <= 1'b1;
        end
        else
        begin
            phase_q <= phase_d;
            txd_q   <= txd_d;
            rxl_q   <= rxl_d;
            rxd_q   <= rxd_d;
        end
    end

    assign phase   = phase_q;
    assign txd_out = txd_q;
    assign rx_data = rxd_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_ir_off_passes;
        @(posedge clk) disable iff (!rst_n)
        !ir_en |=> txd_q == $past(tx_bit);
    endproperty
    a_ir_off_passes: assert property (p_ir_off_passes)
        else $error("Pin differs from transmit bit with infrared off");

    property p_quarter_pulse;
        @(posedge clk) disable iff (!rst_n)
        ir_en && !tx_bit && pulse_sel == 2'h3 && phase_q == 5'h07 ##0 !bit_start
        |=> txd_q ##0 1'b1;
    endproperty
    a_quarter_pulse: assert property (p_quarter_pulse)
        else $error("Quarter pulse ended early");

    property p_default_width;
        @(posedge clk) disable iff (!rst_n)
        ir_en && !tx_bit && pulse_sel == 2'h0 && phase_q == 5'h06 |=> !txd_q;
    endproperty
    a_default_width: assert property (p_default_width)
        else $error("Three sixteenths pulse too long");

endmodule

// >>> design/sacir_pkg.sv
// ----------------------------------------------------------------
// Alternative serial control: shared constants and types
// ----------------------------------------------------------------
package sacir_pkg;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_MAP   = 3'h0;    // Alternate map select
    localparam logic [2:0] IDX_ACR1  = 3'h1;    // serial_alt_control_one
    localparam logic [2:0] IDX_ACR2  = 3'h2;    // serial_alt_control_two
    localparam logic [2:0] IDX_STAT  = 3'h3;    // Sticky event status
    localparam logic [2:0] IDX_MASK  = 3'h4;    // Interrupt mask
    localparam logic [2:0] IDX_LAST  = 3'h4;    // Highest mapped index

    // ------------------------------------------------------------
    // Status and mask bit positions
    // ------------------------------------------------------------
    localparam int ST_BRK  = 0;                 // Break detected
    localparam int ST_BERR = 1;                 // Bit error detected

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ACR   = 8'h00;   // Both control registers
    localparam logic [1:0] RST_FLAGS = 2'h0;    // Status and mask

    // ------------------------------------------------------------
    // Narrow pulse codes and widths in 1/32 bit steps
    // ------------------------------------------------------------
    localparam logic [1:0] NP_3_16 = 2'h0;      // Three sixteenths
    localparam logic [1:0] NP_1_16 = 2'h1;      // One sixteenth
    localparam logic [1:0] NP_1_32 = 2'h2;      // One thirty-second
    localparam logic [1:0] NP_1_4  = 2'h3;      // One quarter
    localparam logic [4:0] W_3_16  = 5'h06;
    localparam logic [4:0] W_1_16  = 5'h02;
    localparam logic [4:0] W_1_32  = 5'h01;
    localparam logic [4:0] W_1_4   = 5'h08;

    // ------------------------------------------------------------
    // Bit error modes and their sample phases within a bit
    // ------------------------------------------------------------
    localparam logic [1:0] BEM_OFF  = 2'h0;     // Detection off
    localparam logic [1:0] BEM_EARLY = 2'h1;    // Sample at 9/16
    localparam logic [1:0] BEM_LATE = 2'h2;     // Sample at 13/16
    localparam logic [4:0] PH_EARLY = 5'h12;
    localparam logic [4:0] PH_LATE  = 5'h1a;
    localparam logic [4:0] PH_LAST  = 5'h1e;    // Mode 3: 15/16
    localparam logic [4:0] PH_MID   = 5'h10;    // Break sampling point

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam logic [3:0] BRK_BITS = 4'hb;     // Low bits making a break

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       infrared_enable;            // Bit 7
        logic [1:0] narrow_pulse_select;        // Bits 6:5
        logic [1:0] rsvd;                       // Bits 4:3, read zero
        logic [1:0] bit_error_mode_sel;         // Bits 2:1
        logic       break_detect_feature_en;    // Bit 0
    } sacir_acr2_type;

    typedef struct packed {
        logic [5:0] rsvd;                       // Read zero
        logic       bit_error_irq_en;           // Bit 1
        logic       break_irq_en;               // Bit 0
    } sacir_acr1_type;

    typedef struct packed {
        logic       valid;                      // Data phase pending
        logic       write;                      // Write transfer
        logic [2:0] idx;                        // Register index
        logic       mapped;                     // Index is decoded
    } sacir_dphase_type;

endpackage

// >>> design/sacir_top.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Alternative serial control registers with infrared and break
// ----------------------------------------------------------------
// Operation
// - Second control reachable only when map selected
// - Infrared enable switches modulator and demodulator
// - Pulse codes 11, 10, 01 give 1/4, 1/32, 1/16
// - Bit error mode field sets detection behaviour
// - Break detect enable switches break circuitry
// - Bit error enable gates its interrupt request
// - Break enable gates its interrupt request
module sacir_top #(
    parameter logic [3:0] BREAK_BITS = sacir_pkg::BRK_BITS  // Low bits for a break
) (
    input  wire logic        MCLK,       // 20 MHz clock
    input  wire logic        NRST,       // Synchronous reset, low
    input  wire logic        HSEL,       // Slave select
    input  wire logic [31:0] HADDR,      // Byte address
    input  wire logic [1:0]  HTRANS,     // Transfer type
    input  wire logic        HWRITE,     // Write transfer
    input  wire logic [2:0]  HSIZE,      // Word only
    input  wire logic [31:0] HWDATA,     // Write data
    input  wire logic        HREADY,     // Bus ready
    output logic      [31:0] HRDATA,     // Read data
    output logic             HREADYOUT,  // Always ready
    output logic             HRESP,      // Always OKAY
    input  wire logic        BIT_START,  // First tick of a bit
    input  wire logic        BIT_TICK,   // 32 ticks per bit
    input  wire logic        TX_BIT,     // Transmitter bit
    input  wire logic        TX_ACTIVE,  // Transmitter busy
    input  wire logic        RXD_PIN,    // Receive pin
    output logic             TXD_PIN,    // Transmit pin
    output logic             RX_DATA,    // Demodulated data
    output logic             IRQ         // Interrupt request
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sacir_pkg::sacir_dphase_type dp_q, dp_d;        // Pending data phase
    sacir_pkg::sacir_acr1_type   acr1_q, acr1_d;    // Interrupt enables
    sacir_pkg::sacir_acr2_type   acr2_q, acr2_d;    // Infrared and detect
    logic                        alternate_map_select_q, alternate_map_select_d;    // alternate_map_select
    logic [1:0]                  stat_q, stat_d;    // Sticky events
    logic [1:0]                  mask_q, mask_d;    // Interrupt mask
    logic [31:0]                 rdata_q, rdata_d;  // Read data
    logic                        ready_q;           // Ready flop
    logic                        irq_q, irq_d;      // Interrupt flop
    logic [3:0]                  low_q, low_d;      // Low bit count

    // ------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------
    logic                        accept;            // Address phase taken
    logic [2:0]                  a_idx;             // Address index
    logic                        rd_stat;           // Status read now
    logic [1:0]                  set_ev;            // Events this cycle
    logic                        brk_evt;           // Break found
    logic                        berr_evt;          // Bit error found
    logic [4:0]                  phase;             // Bit phase
    logic [4:0]                  samp_ph;           // Bit error sample
    logic                        rx_bit;            // Demodulated bit
    logic                        txd;               // Shaped pin

    // ------------------------------------------------------------
    // Infrared physical layer
    // ------------------------------------------------------------
    sacir_irphy u_phy (
        .clk       (MCLK),
        .rst_n     (NRST),
        .ir_en     (acr2_q.infrared_enable),
        .pulse_sel (acr2_q.narrow_pulse_select),
        .bit_start (BIT_START),
        .bit_tick  (BIT_TICK),
        .tx_bit    (TX_BIT),
        .rxd_in    (RXD_PIN),
        .phase     (phase),
        .txd_out   (txd),
        .rx_data   (rx_bit)
    );

    // ------------------------------------------------------------
    // Bus address phase decode
    // ------------------------------------------------------------
    // Zero wait states: every address phase is taken when HREADY is
    // high, so the data phase always completes in one cycle.
    always_comb
    begin
        accept  = HSEL && HTRANS[1] && HREADY;
        a_idx   = HADDR[4:2];
        rd_stat = accept && !HWRITE && (a_idx == sacir_pkg::IDX_STAT);
        dp_d    = '0;
        if (accept)
        begin
            dp_d.valid  = 1'b1;
            dp_d.write  = HWRITE;
            dp_d.idx    = a_idx;
            dp_d.mapped = (a_idx <= sacir_pkg::IDX_LAST);
        end
    end

    // ------------------------------------------------------------
    // Read data, prepared during the address phase
    // ------------------------------------------------------------
    // Hidden registers read as zero so software can probe the map.
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (accept && !HWRITE)
        begin
            case (a_idx)
                sacir_pkg::IDX_MAP:  rdata_d = {31'h0000_0000, alternate_map_select_q};
                sacir_pkg::IDX_ACR1: rdata_d = alternate_map_select_q ? {24'h00_0000, acr1_q} : 32'h0000_0000;
                sacir_pkg::IDX_ACR2: rdata_d = alternate_map_select_q ? {24'h00_0000, acr2_q} : 32'h0000_0000;
                sacir_pkg::IDX_STAT: rdata_d = {30'h0000_0000, stat_q};
                sacir_pkg::IDX_MASK: rdata_d = {30'h0000_0000, mask_q};
                default:             rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register writes in the data phase
    // ------------------------------------------------------------
    always_comb
    begin
        alternate_map_select_d = alternate_map_select_q;
        acr1_d = acr1_q;
        acr2_d = acr2_q;
        mask_d = mask_q;
        if (dp_q.valid && dp_q.write && dp_q.mapped)
        begin
            case (dp_q.idx)
                sacir_pkg::IDX_MAP:
                    alternate_map_select_d = HWDATA[0];
                sacir_pkg::IDX_ACR1:
                begin
                    // Gated by the map select like the second register
                    if (alternate_map_select_q)
                    begin
                        acr1_d.bit_error_irq_en = HWDATA[1];
                        acr1_d.break_irq_en     = HWDATA[0];
                    end
                end
                sacir_pkg::IDX_ACR2:
                begin
                    if (alternate_map_select_q)
                    begin
                        acr2_d.infrared_enable         = HWDATA[7];
                        acr2_d.narrow_pulse_select     = HWDATA[6:5];
                        acr2_d.bit_error_mode_sel      = HWDATA[2:1];
                        acr2_d.break_detect_feature_en = HWDATA[0];
                    end
                end
                sacir_pkg::IDX_MASK:
                    mask_d = HWDATA[1:0];
                default:
                    mask_d = mask_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Break detection
    // ------------------------------------------------------------
    // Counts whole low bits at mid-bit; fires once per break and
    // rearms only after the line returns high or break detect is switched off.
    always_comb
    begin
        low_d   = low_q;
        brk_evt = 1'b0;
        if (!acr2_q.break_detect_feature_en)
            low_d = 4'h0;
        else if (BIT_TICK && phase == sacir_pkg::PH_MID)
        begin
            if (rx_bit)
                low_d = 4'h0;
            else if (low_q != BREAK_BITS)
            begin
                low_d   = low_q + 4'h1;
                brk_evt = (low_q == BREAK_BITS - 4'h1);
            end
        end
    end

    // ------------------------------------------------------------
    // Bit error detection
    // ------------------------------------------------------------
    // Compares what we send with what comes back at the chosen phase.
    always_comb
    begin
        case (acr2_q.bit_error_mode_sel)
            sacir_pkg::BEM_EARLY: samp_ph = sacir_pkg::PH_EARLY;
            sacir_pkg::BEM_LATE:  samp_ph = sacir_pkg::PH_LATE;
            default:              samp_ph = sacir_pkg::PH_LAST;
        endcase
        berr_evt = (acr2_q.bit_error_mode_sel != sacir_pkg::BEM_OFF) && TX_ACTIVE
                   && BIT_TICK && (phase == samp_ph) && (rx_bit != TX_BIT);
    end

    // ------------------------------------------------------------
    // Sticky status and interrupt
    // ------------------------------------------------------------
    // A read clears the flags, but an event in the same cycle wins.
    always_comb
    begin
        set_ev = 2'b00;
        set_ev[sacir_pkg::ST_BRK]  = brk_evt;
        set_ev[sacir_pkg::ST_BERR] = berr_evt;
        stat_d = (rd_stat ? 2'b00 : stat_q) | set_ev;
        irq_d  = (stat_q[sacir_pkg::ST_BERR] && mask_q[sacir_pkg::ST_BERR]
                  && acr1_q.bit_error_irq_en)
              || (stat_q[sacir_pkg::ST_BRK] && mask_q[sacir_pkg::ST_BRK]
                  && acr1_q.break_irq_en);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            dp_q    <= '0;
            alternate_map_select_q  <= 1'b0;
            acr1_q  <= sacir_pkg::RST_ACR;
            acr2_q  <= sacir_pkg::RST_ACR;
            stat_q  <= sacir_pkg::RST_FLAGS;
            mask_q  <= sacir_pkg::RST_FLAGS;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b1;
            irq_q   <= 1'b0;
            low_q   <= 4'h0;
        end
        else
        begin
            dp_q    <= dp_d;
            alternate_map_select_q  <= alternate_map_select_d;
            acr1_q  <= acr1_d;
            acr2_q  <= acr2_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            rdata_q <= rdata_d;
            ready_q <= 1'b1;
            irq_q   <= irq_d;
            low_q   <= low_d;
        end
    end

    assign HRDATA    = rdata_q;
    assign HREADYOUT = ready_q;
    assign HRESP     = 1'b0;
    assign TXD_PIN   = txd;
    assign RX_DATA   = rx_bit;
    assign IRQ       = irq_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_acr2_locked;
        @(posedge MCLK) disable iff (!NRST)
        dp_q.valid && dp_q.write && dp_q.idx == 3'h2 && !alternate_map_select_q |=> $stable(acr2_q);
    endproperty
    a_acr2_locked: assert property (p_acr2_locked)
        else $error("Second control register written while map not selected");

    property p_acr2_hidden;
        @(posedge MCLK) disable iff (!NRST)
        accept && !HWRITE && a_idx == 3'h2 && !alternate_map_select_q |=> HRDATA == 32'h0000_0000;
    endproperty
    a_acr2_hidden: assert property (p_acr2_hidden)
        else $error("Second control register readable while map not selected");

    property p_berr_sets;
        @(posedge MCLK) disable iff (!NRST)
        berr_evt |=> stat_q[1];
    endproperty
    a_berr_sets: assert property (p_berr_sets)
        else $error("Bit error not recorded");

    property p_berr_off;
        @(posedge MCLK) disable iff (!NRST)
        acr2_q.bit_error_mode_sel == 2'h0 |-> !berr_evt;
    endproperty
    a_berr_off: assert property (p_berr_off)
        else $error("Bit error raised while detection off");

    property p_brk_off;
        @(posedge MCLK) disable iff (!NRST)
        !acr2_q.break_detect_feature_en |=> low_q == 4'h0 && !$rose(stat_q[0]);
    endproperty
    a_brk_off: assert property (p_brk_off)
        else $error("Break circuitry active while disabled");

    property p_berr_irq_gate;
        @(posedge MCLK) disable iff (!NRST)
        !stat_q[0] && !acr1_q.bit_error_irq_en |=> !IRQ;
    endproperty
    a_berr_irq_gate: assert property (p_berr_irq_gate)
        else $error("Bit error interrupt not blocked");

    property p_berr_irq_on;
        @(posedge MCLK) disable iff (!NRST)
        stat_q[1] && mask_q[1] && acr1_q.bit_error_irq_en |=> IRQ;
    endproperty
    a_berr_irq_on: assert property (p_berr_irq_on)
        else $error("Bit error interrupt missing");

    property p_brk_irq_gate;
        @(posedge MCLK) disable iff (!NRST)
        !stat_q[1] && !acr1_q.break_irq_en |=> !IRQ;
    endproperty
    a_brk_irq_gate: assert property (p_brk_irq_gate)
        else $error("Break interrupt not blocked");

    property p_brk_irq_on;
        @(posedge MCLK) disable iff (!NRST)
        stat_q[0] && mask_q[0] && acr1_q.break_irq_en |=> IRQ;
    endproperty
    a_brk_irq_on: assert property (p_brk_irq_on)
        else $error("Break interrupt missing");

endmodule
